/* logic/ams_pkg.sv */
// Constants and types for the interrupt-unit mode state controller
package ams_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_BASE   = 8'h00;
    localparam logic [7:0] OFF_STAT   = 8'h04;
    localparam logic [7:0] OFF_ACCESS = 8'h08;
    localparam logic [7:0] OFF_ENTRY  = 8'h0C;
    localparam logic [7:0] OFF_EXIT   = 8'h10;
    localparam logic [7:0] OFF_ID     = 8'h14;
    localparam logic [7:0] OFF_LDR    = 8'h18;
    localparam logic [7:0] OFF_TPR    = 8'h1C;
    localparam logic [7:0] OFF_ICRLO  = 8'h20;
    localparam logic [7:0] OFF_ICRHI  = 8'h24;
    localparam logic [7:0] OFF_DFR    = 8'h28;
    localparam logic [7:0] OFF_SVR    = 8'h2C;
    localparam logic [7:0] OFF_LVT    = 8'h30;
    localparam logic [7:0] OFF_DCR    = 8'h34;
    localparam logic [7:0] OFF_ICNT   = 8'h38;
    localparam logic [7:0] OFF_CCNT   = 8'h3C;
    localparam logic [7:0] OFF_VER    = 8'h40;
    localparam logic [7:0] OFF_SELF   = 8'h44;
    localparam logic [7:0] OFF_IRR    = 8'h48;
    localparam logic [7:0] OFF_ISR    = 8'h4C;
    localparam logic [7:0] OFF_TMR    = 8'h50;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_GE      = 0;
    localparam int BIT_EXT     = 1;
    localparam int BIT_ST_GP   = 0;
    localparam int BIT_ST_HOST = 1;
    localparam int BIT_ST_ABRT = 2;
    localparam int BIT_LVT_MSK = 16;
    localparam int BIT_LID_LO  = 24;
    // ------------------------------------------------------------
    // Values after reset and check patterns
    // ------------------------------------------------------------
    localparam logic [31:0] RST_ZERO  = 32'h0000_0000;
    localparam logic [31:0] RST_DFR   = 32'hFFFF_FFFF;
    localparam logic [31:0] RST_SVR   = 32'h0000_00FF;
    localparam logic [31:0] RST_LVT   = 32'h0001_0000;
    localparam logic [31:0] LIST_MASK = 32'hFFFF_F800;
    localparam logic [31:0] LIST_HIT  = 32'h0000_0800;
    localparam logic [21:0] MSR_BLOCK = 22'h00_0002;
    // Arbitrary neutral version value
    localparam logic [31:0] VER_VALUE = 32'h0001_0010;
    localparam logic [1:0]  RESP_OK   = 2'h0;
    localparam logic [1:0]  RESP_ERR  = 2'h2;
    // ------------------------------------------------------------
    // Mode states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_DIS = 3'b001,
        ST_LEG = 3'b010,
        ST_EXT = 3'b100
    } ams_mode_e;
endpackage

/* logic/ams_top.sv */
// Mode state controller with AXI4-Lite register access
// How it works
// [RULE_01] Fail list entries hitting the controller range
// [RULE_02] Entry fail reloads host; exit fail aborts
// [RULE_03] Two control bits encode the three states
// [RULE_04] Invalid combination faults, state kept
// [RULE_05] Hard reset comes up in legacy mode
// [RULE_06] Load 32-bit id; low byte shown high
// [RULE_07] Reset clears legacy fields and timer counts
// [RULE_08] Vector table cleared, mask bit set
// [RULE_09] Spurious vector 0xFF; version untouched
// [RULE_10] Format register all ones; self register zero
// [RULE_11] Legacy to extended keeps id, makes logical id
// [RULE_12] Clearing enable in legacy disables
// [RULE_13] Legacy INIT keeps id, reinitialises rest
// [RULE_14] Legacy hard reset reloads everything
// [RULE_15] Extended may only go to disabled, id kept
// [RULE_16] Extended straight to legacy faults
// [RULE_17] Extended hard reset lands legacy, all reset
// [RULE_18] Extended INIT keeps mode and id
// [RULE_19] Disabled only goes to legacy
// [RULE_20] Disabled: reset to legacy, INIT stays disabled
// [RULE_21] Passing disabled drops all but id
// [RULE_22] To extended drops logical, sw id, command high
// [RULE_23] Range access outside extended mode faults
// [RULE_24] Other unlisted transitions fault, state kept
`timescale 1ns/1ps
module ams_top (
    input  wire logic        ref_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        init_in,
    input  wire logic [31:0] hw_id_in,
    input  wire logic [31:0] s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    output logic [1:0]       s_axi_bresp_out,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    input  wire logic [31:0] s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    output logic             global_enable_out,
    output logic             extended_mode_enable_out,
    output logic [31:0]      local_id_out,
    output logic             gp_fault_out,
    output logic             host_reload_out,
    output logic             virt_abort_out
);
    import ams_pkg::*;

    ams_mode_e   state;
    ams_mode_e   next_state;
    logic        aw_ok;
    logic        w_ok;
    logic [7:0]  wa;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic        wr_do;
    logic        wr_map;
    logic [31:0] rd_mux;
    logic        rd_map;
    logic        base_wr;
    logic        base_bad;
    logic        regs_wipe;
    logic        regs_live;
    logic        list_hit;
    logic        msr_gp;
    logic        id_vld;
    logic [31:0] id;
    logic [7:0]  sw_id;
    logic        sw_id_vld;
    logic [31:0] logical_destination_reg;
    logic [31:0] task_priority_reg;
    logic [31:0] icr_lo;
    logic [31:0] icr_hi;
    logic [31:0] destination_format_reg;
    logic [31:0] svr;
    logic [31:0] local_vector_table;
    logic [31:0] dcr;
    logic [31:0] icnt;
    logic [31:0] ccnt;
    logic [7:0]  self_vec;
    logic [2:0]  stat;
    logic [31:0] gen_ldr;

    // Byte-lane merge of a write into an old value
    function automatic logic [31:0] merge(input logic [31:0] old);
        logic [31:0] m;
        m = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
        return (old & ~m) | (wd & m);
    endfunction

    // ------------------------------------------------------------
    // AXI4-Lite write channels
    // ------------------------------------------------------------
    // Address and data are held until both arrive, in either order
    assign s_axi_awready_out = !aw_ok;
    assign s_axi_wready_out  = !w_ok;
    assign wr_do = aw_ok && w_ok && !s_axi_bvalid_out;

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            aw_ok <= 1'b0;
            wa    <= 8'h00;
        end else if (s_axi_awvalid_in && !aw_ok) begin
            aw_ok <= 1'b1;
            wa    <= s_axi_awaddr_in[7:0];
        end else if (wr_do) begin
            aw_ok <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            w_ok <= 1'b0;
            wd   <= 32'h0000_0000;
            ws   <= 4'h0;
        end else if (s_axi_wvalid_in && !w_ok) begin
            w_ok <= 1'b1;
            wd   <= s_axi_wdata_in;
            ws   <= s_axi_wstrb_in;
        end else if (wr_do) begin
            w_ok <= 1'b0;
        end
    end

    // Unmapped or read-only targets answer SLVERR
    always_comb begin
        case (wa)
            OFF_BASE, OFF_STAT, OFF_ACCESS, OFF_ENTRY, OFF_EXIT,
            OFF_ID, OFF_LDR, OFF_TPR, OFF_ICRLO, OFF_ICRHI, OFF_DFR,
            OFF_SVR, OFF_LVT, OFF_DCR, OFF_ICNT, OFF_SELF: begin
                wr_map = 1'b1;
            end
            default: begin
                wr_map = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out  <= RESP_OK;
        end else if (wr_do) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out  <= wr_map ? RESP_OK : RESP_ERR;
        end else if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Mode transitions
    // ------------------------------------------------------------
    assign base_wr = wr_do && (wa == OFF_BASE);

    // Requested bit pair checked against the current state
    always_comb begin
        next_state = state;
        base_bad   = 1'b0;
        case ({wd[BIT_EXT], wd[BIT_GE]})
            2'b00: begin
                if (state == ST_LEG || state == ST_EXT) begin
                    next_state = ST_DIS; // RULE_12
                end
            end
            2'b01: begin
                if (state == ST_EXT) begin
                    base_bad = 1'b1; // RULE_16
                end else begin
                    next_state = ST_LEG; // RULE_19
                end
            end
            2'b11: begin
                if (state == ST_DIS) begin
                    base_bad = 1'b1; // RULE_24
                end else begin
                    next_state = ST_EXT; // RULE_11
                end
            end
            default: begin
                base_bad = 1'b1; // RULE_04
            end
        endcase
    end

    // Hard reset lands in legacy mode whatever the old state
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= ST_LEG; // RULE_05 RULE_14 RULE_17 RULE_20
        end else if (init_in) begin
            state <= state; // RULE_18 RULE_20
        end else if (base_wr && !base_bad) begin
            state <= next_state; // RULE_15
        end
    end

    // RULE_03
    assign global_enable_out        = (state != ST_DIS);
    assign extended_mode_enable_out = (state == ST_EXT);

    // ------------------------------------------------------------
    // Identifier
    // ------------------------------------------------------------
    // Caught on the first edge after release, never under reset
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            id_vld <= 1'b0;
            id     <= 32'h0000_0000;
        end else if (!id_vld) begin
            id_vld <= 1'b1;
            id     <= hw_id_in; // RULE_06
        end
    end

    assign local_id_out = id;
    // Cluster in the high half, one-hot member in the low half
    assign gen_ldr = {id[19:4], 16'h0001 << id[3:0]};

    // ------------------------------------------------------------
    // Controller registers
    // ------------------------------------------------------------
    // INIT or passing through disabled wipes all but the id
    assign regs_wipe = init_in || (base_wr && !base_bad &&
                       (next_state == ST_DIS) != (state == ST_DIS));
    assign regs_live = wr_do && !init_in && (state != ST_DIS);

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            logical_destination_reg       <= RST_ZERO; // RULE_07
            task_priority_reg       <= RST_ZERO;
            icr_lo    <= RST_ZERO;
            icr_hi    <= RST_ZERO;
            dcr       <= RST_ZERO;
            icnt      <= RST_ZERO;
            ccnt      <= RST_ZERO;
            local_vector_table       <= RST_LVT; // RULE_08
            svr       <= RST_SVR; // RULE_09
            destination_format_reg       <= RST_DFR; // RULE_10
            self_vec  <= 8'h00;
            sw_id     <= 8'h00;
            sw_id_vld <= 1'b0;
        end else if (regs_wipe) begin
            logical_destination_reg       <= RST_ZERO; // RULE_13 RULE_18 RULE_21
            task_priority_reg       <= RST_ZERO;
            icr_lo    <= RST_ZERO;
            icr_hi    <= RST_ZERO;
            dcr       <= RST_ZERO;
            icnt      <= RST_ZERO;
            ccnt      <= RST_ZERO;
            local_vector_table       <= RST_LVT;
            svr       <= RST_SVR;
            destination_format_reg       <= RST_DFR;
            self_vec  <= 8'h00;
            // INIT keeps the id register as software last saw it
            sw_id_vld <= init_in && sw_id_vld;
        end else if (base_wr && !base_bad && state == ST_LEG &&
                     next_state == ST_EXT) begin
            logical_destination_reg       <= gen_ldr; // RULE_11 RULE_22
            icr_hi    <= RST_ZERO;
            sw_id_vld <= 1'b0;
        end else begin
            // Timer counts down from the last initial count
            if (ccnt != RST_ZERO) begin
                ccnt <= ccnt - 32'h0000_0001;
            end
            if (regs_live) begin
                case (wa)
                    OFF_LDR: begin
                        if (state == ST_LEG) begin
                            logical_destination_reg <= merge(logical_destination_reg);
                        end
                    end
                    OFF_ID: begin
                        if (state == ST_LEG) begin
                            sw_id     <= wd[31:24];
                            sw_id_vld <= 1'b1;
                        end
                    end
                    OFF_TPR:   task_priority_reg    <= merge(task_priority_reg);
                    OFF_ICRLO: icr_lo <= merge(icr_lo);
                    OFF_ICRHI: icr_hi <= merge(icr_hi);
                    OFF_SVR:   svr    <= merge(svr);
                    OFF_LVT:   local_vector_table    <= merge(local_vector_table);
                    OFF_DCR:   dcr    <= merge(dcr);
                    OFF_ICNT: begin
                        icnt <= merge(icnt);
                        ccnt <= merge(icnt);
                    end
                    OFF_DFR: begin
                        if (state == ST_LEG) begin
                            destination_format_reg <= merge(destination_format_reg);
                        end
                    end
                    OFF_SELF: begin
                        if (state == ST_EXT) begin
                            self_vec <= wd[7:0];
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Fault checks and sticky status
    // ------------------------------------------------------------
    // Low 32 bits of a transition-list entry, masked compare
    assign list_hit = ((wd & LIST_MASK) == LIST_HIT); // RULE_01
    assign msr_gp   = wr_do && (wa == OFF_ACCESS) &&
                      (wd[31:10] == MSR_BLOCK) && (state != ST_EXT);

    // One-cycle event pulses for the core
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            gp_fault_out    <= 1'b0;
            host_reload_out <= 1'b0;
            virt_abort_out  <= 1'b0;
        end else begin
            gp_fault_out    <= (base_wr && base_bad) || msr_gp; // RULE_23
            host_reload_out <= wr_do && wa == OFF_ENTRY && list_hit; // RULE_02
            virt_abort_out  <= wr_do && wa == OFF_EXIT && list_hit; // RULE_02
        end
    end

    // Write one to clear; a new event in the same cycle wins
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stat <= 3'h0;
        end else begin
            stat <= (stat & ~((wr_do && wa == OFF_STAT) ? wd[2:0] : 3'h0))
                  | {virt_abort_out, host_reload_out, gp_fault_out};
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    always_comb begin
        rd_map = 1'b1;
        case (s_axi_araddr_in[7:0])
            OFF_BASE:  rd_mux = {30'h0, extended_mode_enable_out,
                                 global_enable_out};
            OFF_STAT:  rd_mux = {29'h0, stat};
            OFF_ID: begin
                if (state == ST_EXT) begin
                    rd_mux = id;
                end else begin
                    rd_mux = {sw_id_vld ? sw_id : id[7:0], 24'h0};
                end
            end
            OFF_LDR:   rd_mux = logical_destination_reg;
            OFF_TPR:   rd_mux = task_priority_reg;
            OFF_ICRLO: rd_mux = icr_lo;
            OFF_ICRHI: rd_mux = icr_hi;
            OFF_DFR:   rd_mux = (state == ST_EXT) ? RST_ZERO : destination_format_reg;
            OFF_SVR:   rd_mux = svr;
            OFF_LVT:   rd_mux = local_vector_table;
            OFF_DCR:   rd_mux = dcr;
            OFF_ICNT:  rd_mux = icnt;
            OFF_CCNT:  rd_mux = ccnt;
            OFF_VER:   rd_mux = VER_VALUE;
            OFF_SELF:  rd_mux = {24'h0, self_vec};
            // Delivery lives elsewhere; these stay clear here
            OFF_IRR, OFF_ISR, OFF_TMR: rd_mux = RST_ZERO;
            default: begin
                rd_mux = RST_ZERO;
                rd_map = 1'b0;
            end
        endcase
    end

    assign s_axi_arready_out = !s_axi_rvalid_out;

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out  <= 32'h0000_0000;
            s_axi_rresp_out  <= RESP_OK;
        end else if (s_axi_arvalid_in && !s_axi_rvalid_out) begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out  <= rd_mux;
            s_axi_rresp_out  <= rd_map ? RESP_OK : RESP_ERR;
        end else if (s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_NO_INVALID: assert property (@(posedge ref_clk_in) // RULE_04
        disable iff (!rst_n_in)
        !(extended_mode_enable_out && !global_enable_out))
        else $error("invalid mode bit pair");
    AST_LIST_ENTRY: assert property (@(posedge ref_clk_in) // RULE_01
        disable iff (!rst_n_in)
        (wr_do && wa == OFF_ENTRY) |=> (host_reload_out == $past(list_hit)))
        else $error("entry check result wrong");
    AST_LIST_EXIT: assert property (@(posedge ref_clk_in) // RULE_02
        disable iff (!rst_n_in)
        (wr_do && wa == OFF_EXIT && list_hit) |=>
            virt_abort_out && !host_reload_out)
        else $error("exit check did not abort");
    AST_EXT_TO_LEG: assert property (@(posedge ref_clk_in) // RULE_16
        disable iff (!rst_n_in)
        (base_wr && !init_in && state == ST_EXT && wd[1:0] == 2'b01) |=>
            gp_fault_out && state == ST_EXT)
        else $error("extended to legacy accepted");
    AST_LEG_TO_EXT: assert property (@(posedge ref_clk_in) // RULE_11
        disable iff (!rst_n_in)
        (base_wr && !init_in && state == ST_LEG && wd[1:0] == 2'b11) |=>
            state == ST_EXT && logical_destination_reg == gen_ldr && icr_hi == RST_ZERO)
        else $error("legacy to extended wrong");
    AST_DIS_TO_EXT: assert property (@(posedge ref_clk_in) // RULE_24
        disable iff (!rst_n_in)
        (base_wr && !init_in && state == ST_DIS && wd[1:0] == 2'b11) |=>
            gp_fault_out ##1 stat[BIT_ST_GP] && state == ST_DIS)
        else $error("disabled to extended accepted");
    AST_INIT_KEEP: assert property (@(posedge ref_clk_in) // RULE_13
        disable iff (!rst_n_in)
        (init_in && id_vld) |=>
            $stable(state) && $stable(id) && svr == RST_SVR && local_vector_table == RST_LVT)
        else $error("INIT handling wrong");
    AST_MSR_GP: assert property (@(posedge ref_clk_in) // RULE_23
        disable iff (!rst_n_in)
        (wr_do && wa == OFF_ACCESS && wd[31:10] == MSR_BLOCK &&
         state == ST_LEG) |=> gp_fault_out)
        else $error("range access did not fault");
    AST_DIS_WIPE: assert property (@(posedge ref_clk_in) // RULE_21
        disable iff (!rst_n_in)
        (base_wr && !base_bad && !init_in && state == ST_EXT &&
         wd[1:0] == 2'b00) |=>
            state == ST_DIS && task_priority_reg == RST_ZERO && $stable(id))
        else $error("disable did not wipe");
endmodule

/* testbench/ams_core_model.sv */
// Core-side model that issues INIT events to the mode controller
`timescale 1ns/1ps
module ams_core_model (
    input  wire logic clk_in,
    output logic      init_out
);
    // Idle low so no INIT reaches the controller outside a request
    initial init_out = 1'b0;

    // One-cycle INIT pulse, launched just after a rising edge
    task automatic pulse_init();
        @(posedge clk_in);
        init_out <= 1'b1;
        @(posedge clk_in);
        init_out <= 1'b0;
    endtask
endmodule

/* testbench/testbench.sv */
// Self-checking bench for the interrupt-unit mode state controller
`timescale 1ns/1ps
module testbench;
    import ams_pkg::*;
    logic        clk;
    logic        rst_n;
    logic        init;
    logic [31:0] hw_id, lid;
    logic [31:0] awaddr, wdata, araddr, rdata, id_out;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic        ge, extended_mode_enable_alt, gp, host, abrt;
    logic [33:0] exp_q[$];
    int          bad_count, n_checks;
    int          n_gp, n_host, n_abrt;

    ams_core_model core (.clk_in(clk), .init_out(init));
    ams_top uut (.ref_clk_in(clk), .rst_n_in(rst_n), .init_in(init),
        .hw_id_in(hw_id), .s_axi_awaddr_in(awaddr),
        .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF),
        .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
        .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
        .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .global_enable_out(ge), .extended_mode_enable_out(extended_mode_enable_alt),
        .local_id_out(id_out), .gp_fault_out(gp),
        .host_reload_out(host), .virt_abort_out(abrt));

    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Compare and count; four-state compare so unknowns never match
    task automatic chk(input logic [33:0] s, input logic [33:0] e);
        n_checks++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected at %0t seen %h exp %h", $time, s, e);
        end
    endtask

    // ----------------------------------------------------------------
    // AXI4-Lite master tasks
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        logic [1:0] rs;
        awaddr <= {24'h0, a};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        tb = 1'b0;
        while (!tb) begin
            @(negedge clk);
            ta = awready & awvalid;
            tw = wready & wvalid;
            tb = bvalid;
            rs = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        // bready stays up; each following write drives it high again at its start
        chk({32'h0, rs}, {32'h0, RESP_OK});
    endtask

    // Expected answer is queued; the monitor does the compare
    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r = RESP_OK);
        logic t;
        exp_q.push_back({r, d});
        araddr <= {24'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        t = 1'b0;
        while (!t) begin
            @(negedge clk);
            t = arready;
            @(posedge clk);
        end
        arvalid <= 1'b0;
        t = 1'b0;
        while (!t) begin
            @(negedge clk);
            t = rvalid;
            @(posedge clk);
        end
        // rready stays up; the next read starts on this same edge
    endtask

    // Read sticky status, then clear it with write-one
    task automatic st(input logic [31:0] d);
        rd(OFF_STAT, d);
        wr(OFF_STAT, 32'h7);
    endtask

    task automatic hard_reset();
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Read monitor: sampled mid-cycle, where the handshake is settled
    always @(negedge clk) begin
        if (rvalid && rready) begin
            if (exp_q.size() == 0) chk({rresp, rdata}, 34'h3_FFFF_FFFF);
            else chk({rresp, rdata}, exp_q.pop_front());
        end
    end

    // Count fault and abort pulses; each stands one cycle
    always @(negedge clk) begin
        if (gp) n_gp++;
        if (host) n_host++;
        if (abrt) n_abrt++;
    end

    // Watchdog sized well beyond the whole sequence
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        final_report();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(93255));
        {awaddr, wdata, araddr, awvalid, wvalid} = '0;
        {bready, arvalid, rready, rst_n} = '0;
        hw_id = $urandom();
        lid = {hw_id[7:0], 24'h0};
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(OFF_BASE, 32'h1);
        rd(OFF_ID, lid);
        rd(OFF_LDR, RST_ZERO);
        rd(OFF_LVT, RST_LVT);
        rd(OFF_SVR, RST_SVR);
        rd(OFF_VER, VER_VALUE);
        rd(OFF_DFR, RST_DFR);
        chk({ge, extended_mode_enable_alt, id_out}, {2'h2, hw_id});
        $display("reset values done");
        wr(OFF_BASE, 32'h2);
        st(32'h1);
        rd(OFF_BASE, 32'h1);
        wr(OFF_ACCESS, 32'h0000_0BFF);
        st(32'h1);
        for (int i = 0; i < 3; i++) begin
            wr(i == 1 ? OFF_EXIT : OFF_ENTRY, 32'h800 + i * 32'h7FF);
            st(i == 0 ? 32'h2 : (i == 1 ? 32'h4 : 32'h0));
        end
        $display("faults and list checks done");
        wr(OFF_LDR, $urandom());
        wr(OFF_BASE, 32'h3);
        rd(OFF_BASE, 32'h3);
        rd(OFF_ID, hw_id);
        rd(OFF_LDR, {hw_id[19:4], 16'h1 << hw_id[3:0]});
        chk({ge, extended_mode_enable_alt, id_out}, {2'h3, hw_id});
        wr(OFF_BASE, 32'h1);
        st(32'h1);
        rd(OFF_BASE, 32'h3);
        wr(OFF_ACCESS, 32'h0000_0800);
        st(32'h0);
        wr(OFF_TPR, 32'h33);
        core.pulse_init();
        rd(OFF_TPR, RST_ZERO);
        rd(OFF_ID, hw_id);
        $display("extended mode done");
        wr(OFF_TPR, 32'h33);
        wr(OFF_BASE, 32'h0);
        rd(OFF_BASE, 32'h0);
        chk({ge, extended_mode_enable_alt, id_out}, {2'h0, hw_id});
        wr(OFF_BASE, 32'h3);
        st(32'h1);
        core.pulse_init();
        rd(OFF_BASE, 32'h0);
        wr(OFF_BASE, 32'h1);
        rd(OFF_BASE, 32'h1);
        rd(OFF_ID, lid);
        rd(OFF_TPR, RST_ZERO);
        wr(OFF_TPR, 32'h33);
        core.pulse_init();
        rd(OFF_TPR, RST_ZERO);
        rd(OFF_ID, lid);
        $display("disabled and init done");
        wr(OFF_BASE, 32'h3);
        hard_reset();
        rd(OFF_BASE, 32'h1);
        rd(OFF_ID, lid);
        chk({ge, extended_mode_enable_alt, id_out}, {2'h2, hw_id});
        rd(8'h80, RST_ZERO, RESP_ERR);
        chk({n_gp[7:0], n_host[7:0], n_abrt[7:0]}, 24'h04_0101);
        $display("hard reset done");
        final_report();
    end
endmodule
